//--- hdl/owps_slave.sv
// Single pin programming link slave with command mode control
`timescale 1ns/1ps
module owps_slave
	import owps_pkg::*;
#(
	parameter int TON_CYC = TON_US * CLK_MHZ,
	parameter int TCMD_CYC = TCMD_US * CLK_MHZ,
	parameter int TO_CYC = TO_US * CLK_MHZ
)(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic pin_in,
	input wire logic diag_present,
	input wire logic low_voltage,
	output logic pin_out,
	output logic pin_oe,
	output logic analog_en,
	output logic cmd_mode,
	output logic pump_clock_enable,
	output logic nvm_write_enable,
	output logic force_diag_off
);
	typedef struct packed {
		logic sync1;
		logic sync2;
		logic prev;
		owps_state_t state;
		logic [12:0] hi_cnt;
		logic [12:0] lo_cnt;
		logic [13:0] period;
		logic [13:0] to_cnt;
		logic [20:0] up_cnt;
		logic [4:0] bits;
		logic [23:0] shreg;
		logic [7:0] cmd;
		logic [13:0] tcnt;
		logic [4:0] tbit;
		logic dout;
		logic oe;
		logic ton_done;
		logic cmd_mode;
		logic force_diag;
		logic pump_clk;
		logic [15:0] test_ctl;
		logic [15:0] signature;
	} owps_regs_t;

	owps_regs_t r_reg, r_next;
	logic rise, fall, mem_we, bit_val, legal;
	logic [15:0] mem_rdata, rd_word, ctl_word;
	logic [7:0] byte_in;
	logic [15:0] word_in;
	logic [13:0] quarter, hi_w;

	function automatic logic [12:0] sat13(input logic [12:0] v);
		return (v == 13'h1fff) ? v : v + 13'h0001;
	endfunction

	function automatic logic region_ok(input logic [7:0] c);
		return c[7:5] == REGION_NVM || c[7:5] == REGION_REG;
	endfunction

	owps_nvm u_nvm (
		.ref_clk(ref_clk),
		.ce(ce),
		.we(mem_we),
		.addr(r_reg.cmd[4:1]),
		.wdata(word_in),
		.rdata(mem_rdata)
	);

	assign ctl_word = {diag_present, r_reg.force_diag, 1'b0, low_voltage,
		r_reg.pump_clk, 11'h000};

	// Read data selection by region and address
	always_comb begin
		rd_word = 16'h0000;
		if (r_reg.cmd[7:5] == REGION_NVM) begin
			rd_word = mem_rdata;
		end else begin
			unique case (r_reg.cmd[4:1])
				ADDR_CONTROL: rd_word = ctl_word;
				ADDR_TEST: rd_word = r_reg.test_ctl;
				ADDR_SIGNATURE: rd_word = r_reg.signature;
				default: rd_word = 16'h0000;
			endcase
		end
	end

	// Next state of the whole slave
	always_comb begin
		r_next = r_reg;
		mem_we = 1'b0;
		r_next.sync1 = pin_in;
		r_next.sync2 = r_reg.sync1;
		r_next.prev = r_reg.sync2;
		rise = r_reg.sync2 & ~r_reg.prev;
		fall = ~r_reg.sync2 & r_reg.prev;
		bit_val = r_reg.hi_cnt > r_reg.lo_cnt; // RULE_12
		byte_in = {r_reg.shreg[6:0], bit_val};
		// Full data word including the bit that ends on this rise
		word_in = {r_reg.shreg[14:0], bit_val};
		legal = region_ok(byte_in);
		quarter = {2'b00, r_reg.period[13:2]};
		hi_w = r_reg.shreg[23] && r_reg.tbit != TX_HANDOVER ?
			quarter * 14'h0003 : quarter;
		// Power-up timer drives the turn-on delay and the entry window
		if (r_reg.up_cnt != 21'h1fffff) begin
			r_next.up_cnt = r_reg.up_cnt + 21'h000001;
		end
		if (r_reg.up_cnt >= 21'(TON_CYC)) begin
			r_next.ton_done = 1'b1; // RULE_01
		end
		if (r_reg.sync2) begin
			r_next.hi_cnt = sat13(r_reg.hi_cnt);
		end else begin
			r_next.lo_cnt = sat13(r_reg.lo_cnt);
		end
		if (r_reg.to_cnt != 14'h3fff) begin
			r_next.to_cnt = r_reg.to_cnt + 14'h0001;
		end
		if (rise) begin
			r_next.to_cnt = 14'h0000;
			r_next.hi_cnt = 13'h0001; // Rising cycle is already HIGH
			r_next.lo_cnt = 13'h0000;
		end
		unique case (r_reg.state)
			OWPS_IDLE: begin
				// Start: rising edge after a long LOW; never self-started
				if (rise && r_reg.lo_cnt >= 13'(START_CYC)) begin // RULE_05
					r_next.state = OWPS_RX; // RULE_04
					r_next.bits = 5'h00;
				end
			end
			OWPS_RX: begin
				if (rise) begin
					// Rising edge ends a bit; its HIGH/LOW ratio gives the value
					r_next.shreg = {r_reg.shreg[22:0], bit_val}; // RULE_13
					r_next.bits = r_reg.bits + 5'h01; // RULE_06
					r_next.period = {1'b0, r_reg.hi_cnt} + {1'b0, r_reg.lo_cnt};
					if (r_reg.bits == BITS_CMD - 5'h01) begin
						r_next.cmd = byte_in; // RULE_14
						if (r_reg.cmd_mode ? !legal : (byte_in != ENTRY_CMD ||
							r_reg.up_cnt >= 21'(TCMD_CYC))) begin
							r_next.state = OWPS_WAIT; // RULE_23 RULE_19 RULE_02
						end
					end else if (r_reg.bits == BITS_WRITE - 5'h01 &&
						!r_reg.cmd[RW_BIT]) begin
						r_next.state = OWPS_WAIT;
						if (!r_reg.cmd_mode) begin
							if ({r_reg.shreg[14:0], bit_val} == ENTRY_SIG) begin
								r_next.cmd_mode = 1'b1; // RULE_10
							end
						end else if (r_reg.cmd[7:5] == REGION_NVM) begin
							// Writes only land with both enables set
							mem_we = r_reg.pump_clk && r_reg.test_ctl[TST_WREN_BIT]; // RULE_16
						end else begin
							unique case (r_reg.cmd[4:1]) // RULE_20
								ADDR_CONTROL: begin
									r_next.force_diag = r_reg.shreg[CTL_FORCE_BIT - 1];
									r_next.pump_clk = r_reg.shreg[CTL_PUMP_BIT - 1];
								end
								ADDR_TEST: r_next.test_ctl = {r_reg.shreg[14:0], bit_val};
								ADDR_SIGNATURE: r_next.signature = {r_reg.shreg[14:0], bit_val};
								default: ;
							endcase
						end
					end
				end else if (fall && r_reg.bits == BITS_CMD && r_reg.cmd[RW_BIT]) begin
					// Falling edge of master handover bit: take the bus LOW
					r_next.state = OWPS_TKO; // RULE_07
					r_next.oe = 1'b1; // RULE_22
					r_next.dout = 1'b0;
					r_next.tcnt = 14'h0000;
				end
				if (r_reg.to_cnt >= 14'(TO_CYC)) begin
					r_next.state = OWPS_IDLE; // RULE_09
				end
			end
			OWPS_TKO: begin
				r_next.tcnt = r_reg.tcnt + 14'h0001;
				if (r_reg.tcnt == 14'(TKO_CYC - 1)) begin
					r_next.shreg = {rd_word, 8'h00};
					r_next.state = OWPS_TX;
					r_next.tcnt = 14'h0000;
					r_next.tbit = 5'h00;
					r_next.dout = 1'b1;
				end
			end
			OWPS_TX: begin
				// Pace sends at the period measured on the last received bit
				r_next.tcnt = r_reg.tcnt + 14'h0001;
				if (r_reg.tcnt == hi_w - 14'h0001) begin
					r_next.dout = 1'b0; // RULE_12
				end
				if (r_reg.tbit == TX_HANDOVER &&
					r_reg.tcnt == quarter * 14'h0003 - 14'h0001) begin
					r_next.oe = 1'b0; // RULE_21
					r_next.state = OWPS_WAIT;
					r_next.to_cnt = 14'h0000;
				end else if (r_reg.tcnt == r_reg.period - 14'h0001) begin
					r_next.tcnt = 14'h0000;
					r_next.tbit = r_reg.tbit + 5'h01;
					r_next.shreg = {r_reg.shreg[22:0], 1'b0}; // RULE_13
					r_next.dout = 1'b1;
				end
			end
			OWPS_WAIT: begin
				// Stop is a long HIGH; a silent bus falls back on time-out
				if (r_reg.sync2 && r_reg.hi_cnt >= 13'(STOP_CYC)) begin
					r_next.state = OWPS_IDLE; // RULE_08
				end else if (r_reg.to_cnt >= 14'(TO_CYC)) begin
					r_next.state = OWPS_IDLE; // RULE_09
				end
			end
			default: r_next.state = OWPS_IDLE;
		endcase
	end

	// State register; command mode clears only through reset
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			r_reg <= '0;
			// Idle pin is HIGH: avoids a false rising edge after reset
			r_reg.sync1 <= 1'b1;
			r_reg.sync2 <= 1'b1;
			r_reg.prev <= 1'b1;
			r_reg.test_ctl <= TEST_RESET;
			r_reg.signature <= SIG_RESET;
		end else if (ce) begin
			r_reg <= r_next; // RULE_11
		end
	end

	assign pin_out = r_reg.dout;
	assign pin_oe = r_reg.oe;
	assign cmd_mode = r_reg.cmd_mode;
	assign analog_en = r_reg.ton_done && !r_reg.cmd_mode; // RULE_01
	assign pump_clock_enable = r_reg.pump_clk;
	assign nvm_write_enable = r_reg.test_ctl[TST_WREN_BIT];
	assign force_diag_off = r_reg.force_diag;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	quiet_outside_a: assert property (!cmd_mode |-> !pin_oe) // RULE_19
		else $error("pin driven outside command mode");
	mode_sticky_a: assert property (cmd_mode |=> cmd_mode) // RULE_11
		else $error("command mode left without reset");
	analog_off_a: assert property (analog_en |-> !cmd_mode &&
		r_reg.up_cnt >= 21'(TON_CYC)) // RULE_01
		else $error("analog mode in wrong condition");
	takeover_low_a: assert property ($rose(pin_oe) |-> !pin_out [*8]) // RULE_22
		else $error("takeover not held low");
	read_only_a: assert property ($rose(pin_oe) |->
		r_reg.cmd[RW_BIT] && region_ok(r_reg.cmd)) // RULE_07
		else $error("drive without legal read command");
	release_zero_a: assert property ($fell(pin_oe) |-> $past(!pin_out)) // RULE_21
		else $error("handover bit not zero at release");
	timeout_idle_a: assert property (r_reg.state == OWPS_RX &&
		r_reg.to_cnt >= 14'(TO_CYC) && ce |=> r_reg.state == OWPS_IDLE) // RULE_09
		else $error("time-out did not idle the link");
	reserved_drop_a: assert property (r_reg.state == OWPS_RX && rise && ce &&
		r_reg.cmd_mode && r_reg.bits == 5'h07 && !legal
		|=> r_reg.state == OWPS_WAIT) // RULE_23
		else $error("reserved region not ignored");
	entry_window_a: assert property ($rose(cmd_mode) |->
		$past(r_reg.up_cnt) < 21'(TCMD_CYC)) // RULE_02
		else $error("entry accepted outside window");

	entry_seen_c: cover property ($rose(cmd_mode));
	read_done_c: cover property ($fell(pin_oe));
	nvm_write_c: cover property (mem_we && ce);
endmodule

//--- shared/owps_pkg.sv
// Constants and types for the single pin programming link slave
// Function
// [RULE_01] After reset and turn-on delay, run analog output mode from stored data.
// [RULE_02] Master sends entry sequence only inside the window after power-on reset.
// [RULE_03] Master overdrives the enabled analog buffer while sending entry sequence.
// [RULE_04] External hardware is always master; device never starts a transfer.
// [RULE_05] Frame opens with rising edge after a long enough LOW level.
// [RULE_06] One command byte follows the start; data follows with no gap.
// [RULE_07] Read commands put a handover bit before and after the data.
// [RULE_08] Master closes each frame with rising edge then long enough HIGH.
// [RULE_09] No rising edge within time-out: drop the frame, go idle.
// [RULE_10] Entry uses a special write with two signature bytes, framed normally.
// [RULE_11] Command mode holds until power-on reset; nothing else leaves it.
// [RULE_12] Each bit starts HIGH; short pulse is 0, long pulse is 1.
// [RULE_13] Words travel most significant byte first.
// [RULE_14] Command byte: region bits 7-5, address bits 4-1, read flag bit 0.
// [RULE_15] Master write: start, command with flag 0, two bytes, stop.
// [RULE_16] Master sets both nvm enables and waits pump settle time before writes.
// [RULE_17] Master waits programming time between writes to different addresses.
// [RULE_18] Master rewrites the checksum after any nonvolatile change.
// [RULE_19] Outside command mode, ignore digital traffic and stay in analog mode.
// [RULE_20] Command mode exposes nvm words, control, test control and signature.
// [RULE_21] Party handing over sends a 0 and releases at three quarters of period.
// [RULE_22] Party taking over drives LOW right after the handover falling edge.
// [RULE_23] Reserved regions get no response and change no state.
package owps_pkg;
	localparam int CLK_MHZ = 50;
	localparam int START_US = 5;
	localparam int START_CYC = START_US * CLK_MHZ;
	localparam int STOP_US = 5;
	localparam int STOP_CYC = STOP_US * CLK_MHZ;
	localparam int TO_US = 220;
	localparam int TKO_US = 2;
	localparam int TKO_CYC = TKO_US * CLK_MHZ;
	localparam int TON_US = 2000;
	localparam int TCMD_US = 20000;
	// Region codes and field positions of the command byte
	localparam logic [2:0] REGION_NVM = 3'h0;
	localparam logic [2:0] REGION_REG = 3'h4;
	localparam int RW_BIT = 0;
	// Register addresses inside the register region
	localparam logic [3:0] ADDR_CONTROL = 4'h1;
	localparam logic [3:0] ADDR_TEST = 4'h2;
	localparam logic [3:0] ADDR_SIGNATURE = 4'h3;
	// Control and test control register fields, and register reset values
	localparam int CTL_DIAG_BIT = 15;
	localparam int CTL_FORCE_BIT = 14;
	localparam int CTL_LOWV_BIT = 12;
	localparam int CTL_PUMP_BIT = 11;
	localparam int TST_WREN_BIT = 0;
	localparam logic [15:0] TEST_RESET = 16'h0000;
	localparam logic [15:0] SIG_RESET = 16'h0000;
	// Entry command byte and signature; values are arbitrary
	localparam logic [7:0] ENTRY_CMD = 8'h86;
	localparam logic [15:0] ENTRY_SIG = 16'h5aa5;
	localparam logic [4:0] BITS_CMD = 5'h08;
	localparam logic [4:0] BITS_WRITE = 5'h18;
	localparam logic [4:0] TX_HANDOVER = 5'h10;
	typedef enum logic [2:0] {
		OWPS_IDLE = 3'b000,
		OWPS_RX = 3'b001,
		OWPS_TKO = 3'b010,
		OWPS_TX = 3'b011,
		OWPS_WAIT = 3'b100
	} owps_state_t;
endpackage

//--- hdl/owps_nvm.sv
// Sixteen word nonvolatile array model with registered read data
`timescale 1ns/1ps
module owps_nvm
	import owps_pkg::*;
(
	input wire logic ref_clk,
	input wire logic ce,
	input wire logic we,
	input wire logic [3:0] addr,
	input wire logic [15:0] wdata,
	output logic [15:0] rdata
);
	logic [15:0] mem [16];

	// Array has no reset: contents model stored data across power cycles
	always_ff @(posedge ref_clk) begin
		if (ce) begin
			if (we) begin
				mem[addr] <= wdata;
			end
			rdata <= mem[addr];
		end
	end
endmodule

//--- test/owps_mst.sv
// Master model that drives the shared programming pin
`timescale 1ns/1ps
module owps_mst (
	input wire logic ref_clk,
	input wire logic s_out,
	input wire logic s_oe,
	output logic pin
);
	logic m_oe = 1'b1;
	logic m_out = 1'b1;
	// Pull-up: a released line reads high; a driven LOW wins
	assign pin = !((s_oe && !s_out) || (m_oe && !m_out));
	task hold(input logic e, input logic v, input int n);
		m_oe = e;
		m_out = v;
		repeat (n) @(negedge ref_clk);
	endtask
	// Period of 40 cycles; short HIGH is 0, long HIGH is 1
	task tbit(input logic b);
		hold(1, 1, b ? 30 : 10);
		hold(1, 0, b ? 10 : 30);
	endtask
	task tbyte(input logic [7:0] b);
		for (int i = 7; i >= 0; i--)
			tbit(b[i]);
	endtask
	// Long LOW, then the first bit's rise opens the frame
	task head(input logic [7:0] c);
		hold(1, 0, 260);
		tbyte(c);
	endtask
	task stop();
		// Margin past the stop time: after a read the rise comes late
		hold(1, 1, 300);
	endtask
	task wr(input logic [7:0] c, input logic [15:0] d);
		head(c);
		tbyte(d[15:8]);
		tbyte(d[7:0]);
		stop();
	endtask
	// Handover: a 0 bit, driver released at the end of the period
	task hand(input logic [7:0] c);
		head(c);
		hold(1, 1, 10);
		hold(1, 0, 30);
		m_oe = 0;
	endtask
	task rbit(output logic b, output int lo);
		int hi;
		lo = 0;
		hi = 0;
		while (pin !== 1'b1) begin
			lo++;
			@(negedge ref_clk);
		end
		while (pin === 1'b1) begin
			hi++;
			@(negedge ref_clk);
		end
		b = hi > 20;
	endtask
	// Takes the bus back right after the slave's handover fall
	task rd(input logic [7:0] c, output logic [15:0] w, output int tko,
		output logic hb);
		int lo;
		hand(c);
		rbit(w[15], tko);
		tko += 30;
		for (int i = 14; i >= 0; i--)
			rbit(w[i], lo);
		rbit(hb, lo);
		hold(1, 0, 10);
		stop();
	endtask
endmodule

//--- test/tb.sv
// Testbench for the programming link slave
`timescale 1ns/1ps
module tb;
	import owps_pkg::*;
	localparam int TO = 1000;
	localparam int TON = 200;
	localparam int TCMD = 20000;
	// Shortened pump settle and programming wait before nvm writes
	localparam int PROG = 500;
	typedef struct packed {
		logic [7:0] c;
		logic [15:0] d;
		logic [15:0] e;
	} owps_row_t;
	// Write, then read back: control, test control, nvm, unknown, signature
	// The nvm word at the top address stands in for the checksum
	owps_row_t rows [6] = '{
		'{8'h82, 16'hffff, 16'hd800},
		'{8'h84, 16'h0001, 16'h0001},
		'{8'h0a, 16'h1234, 16'h1234},
		'{8'h1e, 16'ha5c3, 16'ha5c3},
		'{8'h8e, 16'hffff, 16'h0000},
		'{8'h86, 16'h5aa5, 16'h5aa5}
	};
	logic ref_clk = 0;
	logic rst_n = 0;
	logic ce = 1;
	logic diag = 1;
	logic lowv = 1;
	int oe_cnt = 0;
	logic pin, p_out, p_oe, ana, cmdm, pump, nvwe, fdo, hb;
	logic [15:0] w;
	int tko;
	int cyc = 0;
	int fails = 0;
	int checks = 0;
	owps_slave #(.TON_CYC(TON), .TCMD_CYC(TCMD), .TO_CYC(TO)) owps_slave_inst (
		.ref_clk(ref_clk), .rst_n(rst_n), .ce(ce), .pin_in(pin),
		.diag_present(diag), .low_voltage(lowv), .pin_out(p_out),
		.pin_oe(p_oe), .analog_en(ana), .cmd_mode(cmdm),
		.pump_clock_enable(pump), .nvm_write_enable(nvwe),
		.force_diag_off(fdo));
	owps_mst owps_mst_inst (.ref_clk(ref_clk), .s_out(p_out), .s_oe(p_oe),
		.pin(pin));
	initial forever #10 ref_clk = ~ref_clk;
	// Hang guard, also records any slave drive
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (p_oe === 1'b1)
			oe_cnt <= oe_cnt + 1;
		if (cyc == 85000) begin
			fails++;
			end_sim();
		end
	end
	task chk(input string n, input logic [15:0] e, input logic [15:0] g);
		checks++;
		if (g !== e) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask
	task rdchk(input logic [7:0] c, input logic [15:0] e);
		owps_mst_inst.rd(c, w, tko, hb);
		chk("data", e, w);
		chk("takeover", 1, tko >= 100 && tko <= 110);
		chk("handover", 0, hb);
	endtask
	// A read with no answer; the long quiet HIGH then closes the frame as a stop
	task probe(input logic [7:0] c);
		int n0;
		n0 = oe_cnt;
		owps_mst_inst.hand(c);
		repeat (TO + 20) @(negedge ref_clk);
		chk("drive", 0, oe_cnt != n0);
	endtask
	task end_sim();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		repeat (4) @(negedge ref_clk);
		rst_n = 1;
		chk("oe", 0, p_oe);
		chk("analog", 0, ana);
		probe(8'h83);
		owps_mst_inst.wr(8'h82, 16'hffff);
		chk("force", 0, fdo);
		chk("analog", 1, ana);
		owps_mst_inst.wr(ENTRY_CMD, ENTRY_SIG);
		chk("cmd", 1, cmdm);
		chk("analog", 0, ana);
		$display("entry done");
		foreach (rows[i]) begin
			// Pump settle before, and programming time between, nvm writes
			if (rows[i].c[7:5] == REGION_NVM)
				repeat (PROG) @(negedge ref_clk);
			owps_mst_inst.wr(rows[i].c, rows[i].d);
			rdchk(rows[i].c | 8'h01, rows[i].e);
			$display("row %0d done", i);
		end
		chk("pump", 1, pump);
		chk("nvwe", 1, nvwe);
		chk("force", 1, fdo);
		// Reserved region: no answer, nvm word kept
		owps_mst_inst.wr(8'h2a, 16'h0000);
		probe(8'h2b);
		rdchk(8'h0b, 16'h1234);
		// Write enable bit cleared, pump clock still on: nvm write dropped
		owps_mst_inst.wr(8'h84, 16'h0000);
		owps_mst_inst.wr(8'h0a, 16'hbeef);
		rdchk(8'h0b, 16'h1234);
		$display("refusals done");
		// Frame cut after four data bits, then silence
		owps_mst_inst.head(8'h82);
		repeat (4) owps_mst_inst.tbit(1'b0);
		owps_mst_inst.hold(1, 1, TO + 20);
		rdchk(8'h83, 16'hd800);
		chk("cmd", 1, cmdm);
		$display("timeout done");
		// Frozen clock enable: a whole write frame passes unseen
		ce = 0;
		owps_mst_inst.wr(8'h82, 16'h0000);
		ce = 1;
		diag = 0;
		lowv = 0;
		rdchk(8'h83, 16'h4800);
		$display("enable done");
		rst_n = 0;
		@(negedge ref_clk);
		chk("cmd", 0, cmdm);
		chk("pump", 0, pump);
		rst_n = 1;
		repeat (TON + 10) @(negedge ref_clk);
		chk("analog", 1, ana);
		// Entry after the window has closed is ignored
		repeat (TCMD) @(negedge ref_clk);
		owps_mst_inst.wr(ENTRY_CMD, ENTRY_SIG);
		chk("cmd", 0, cmdm);
		chk("analog", 1, ana);
		$display("reset done");
		end_sim();
	end
endmodule
